// [include/cisu_pkg.sv]
// cisu_pkg: constants and types for the cpu interrupt service unit
// assumes one 10 MHz clock and an apb master for software access
package cisu_pkg;
	// ----------------------------------------------------------------
	// sources
	// ----------------------------------------------------------------
	localparam int N_SRC  = 21;            // total interrupt sources
	localparam int N_NMI  = 6;             // nonmaskable sources
	localparam int N_MASK = 15;            // maskable peripheral sources
	localparam int IDX_W  = 5;
	localparam logic [IDX_W-1:0] SRC_RESET = 5'h00;
	localparam logic [IDX_W-1:0] SRC_MASK0 = 5'h06;
	localparam logic [N_NMI-1:0] NMI_RST   = 6'h01; // reset vector owed
	// ----------------------------------------------------------------
	// condition flags
	// ----------------------------------------------------------------
	localparam int          GMASK_BIT = 4;  // global maskable-interrupt mask
	localparam logic [7:0]  FLAGS_RST = 8'h10;
	// ----------------------------------------------------------------
	// return stack and vectors
	// ----------------------------------------------------------------
	localparam int          SP_W       = 6;
	localparam int          STK_DEPTH  = 40;
	localparam logic [SP_W-1:0] FRAME_LEN = 6'h05;
	localparam logic [SP_W-1:0] STK_ROOM  = 6'h23; // depth minus one frame
	localparam logic [2:0]  FRAME_LAST = 3'h4;
	localparam logic [15:0] VEC_TOP    = 16'hFFFE;
	// ----------------------------------------------------------------
	// apb register map
	// ----------------------------------------------------------------
	localparam logic [7:0] A_COND = 8'h00;  // condition flags, rw
	localparam logic [7:0] A_LEN  = 8'h04;  // local enables, rw
	localparam logic [7:0] A_PEND = 8'h08;  // pending flags, w1c
	localparam logic [7:0] A_STAT = 8'h0C;  // status, ro
	localparam int ST_NMI_LSB = 0;
	localparam int ST_FSM_LSB = 8;
	localparam int ST_SP_LSB  = 16;
	// ----------------------------------------------------------------
	// sequencer states
	// ----------------------------------------------------------------
	typedef enum logic [1:0] {
		ST_IDLE = 2'b00,
		ST_PUSH = 2'b01,
		ST_VEC  = 2'b10,
		ST_POP  = 2'b11
	} cisu_state_t;
endpackage

// [hdl/cisu_prio_enc.sv]
// cisu_prio_enc: fixed priority pick, lowest index wins
// assumes requests are already gated by every mask
`timescale 1ns/1ps
module cisu_prio_enc (
	input  wire logic [cisu_pkg::N_SRC-1:0] req_i,
	output logic                            valid_o,
	output logic [cisu_pkg::IDX_W-1:0]      idx_o
);
	// scan from low priority upward so the highest one is kept
	always_comb begin
		valid_o = 1'b0;
		idx_o   = '0;
		for (int k = cisu_pkg::N_SRC - 1; k >= 0; k--) begin
			if (req_i[k]) begin
				valid_o = 1'b1;
				idx_o   = cisu_pkg::IDX_W'(k);
			end
		end
	end
endmodule // cisu_prio_enc

// [hdl/cisu_core.sv]
// cisu_core: interrupt recognition, stacking, vectoring and return
// assumes cpu register values are stable while halt_o is high
//
// Operation
// - twenty-one sources, six nonmaskable, fifteen maskable
// - locally disabled source is never recognized
// - enabled event sets its pending flag
// - maskable served only with global mask clear
// - service halts cpu, pushes five registers except for reset
// - global mask set after stacking
// - masked requests stay pending until unmasked
// - nonmaskable sources ignore the global mask
// - handler address issued from source vector
// - return restores all registers including flags
// - highest priority pending source served first
`timescale 1ns/1ps
module cisu_core (
	input  wire logic                        mclk_i,
	input  wire logic                        rst_n_i,
	input  wire logic                        apb_psel_i,
	input  wire logic                        apb_penable_i,
	input  wire logic                        apb_pwrite_i,
	input  wire logic [7:0]                  apb_paddr_i,
	input  wire logic [31:0]                 apb_pwdata_i,
	output logic      [31:0]                 apb_prdata_o,
	output logic                             apb_pready_o,
	output logic                             apb_pslverr_o,
	input  wire logic [cisu_pkg::N_MASK-1:0] maskable_evt_i,
	input  wire logic                        clk_fail_i,
	input  wire logic                        liveness_watchdog_i,
	input  wire logic                        illegal_op_i,
	input  wire logic                        soft_trap_instr_i,
	input  wire logic                        external_nmi_request_n_i,
	input  wire logic                        return_from_exception_i,
	input  wire logic [15:0]                 double_accumulator_i,
	input  wire logic [15:0]                 index_x_i,
	input  wire logic [15:0]                 index_y_i,
	input  wire logic [15:0]                 program_counter_i,
	output logic                             halt_o,
	output logic                             vector_valid_o,
	output logic [cisu_pkg::IDX_W-1:0]       vector_idx_o,
	output logic [15:0]                      vector_addr_o,
	output logic                             restore_valid_o,
	output logic [7:0]                       condition_flags_o,
	output logic [15:0]                      double_accumulator_o,
	output logic [15:0]                      index_x_o,
	output logic [15:0]                      index_y_o,
	output logic [15:0]                      program_counter_o,
	output logic                             irq_o
);
	// ----------------------------------------------------------------
	// state
	// ----------------------------------------------------------------
	cisu_pkg::cisu_state_t           state_reg, state_next;
	logic [2:0]                      cnt_reg, cnt_next;
	logic [cisu_pkg::SP_W-1:0]       sp_reg, sp_next;
	logic [7:0]                      condition_flags_reg, flags_next;
	logic [cisu_pkg::N_MASK-1:0]     len_reg, len_next;
	logic [cisu_pkg::N_MASK-1:0]     pend_reg, pend_next;
	logic [cisu_pkg::N_NMI-1:0]      nmi_reg, nmi_next;
	logic                            xnmi_prev_reg;
	logic [cisu_pkg::IDX_W-1:0]      vidx_reg, vidx_next;
	logic                            vvalid_reg, vvalid_next;
	logic                            rvalid_reg, rvalid_next;
	logic [15:0]                     dacc_reg, dacc_next;
	logic [15:0]                     index_x_reg, index_x_next;
	logic [15:0]                     index_y_reg, index_y_next;
	logic [15:0]                     prog_cnt_reg, prog_cnt_next;
	logic [31:0]                     rdata_reg, rdata_next;
	logic [15:0]                     stack_mem [cisu_pkg::STK_DEPTH];
	logic [15:0]                     push_word;
	logic [15:0]                     stk_rd;
	logic                            gmask;
	logic                            ret_ok;
	logic                            take;
	logic                            room;
	logic                            pr_valid;
	logic [cisu_pkg::IDX_W-1:0]      pr_idx;
	logic [cisu_pkg::N_SRC-1:0]      req;
	logic [cisu_pkg::N_MASK-1:0]     evt_en;
	logic [cisu_pkg::N_NMI-1:0]      nmi_set;
	logic [cisu_pkg::N_NMI-1:0]      nmi_clr;
	logic                            wr_en;
	logic                            rd_setup;
	logic                            addr_hit;

	// ----------------------------------------------------------------
	// recognition and arbitration
	// ----------------------------------------------------------------
	assign gmask   = condition_flags_reg[cisu_pkg::GMASK_BIT];
	assign evt_en  = maskable_evt_i & len_reg;
	assign nmi_set = {xnmi_prev_reg & ~external_nmi_request_n_i,
		soft_trap_instr_i, illegal_op_i, liveness_watchdog_i,
		clk_fail_i, 1'b0};
	// nonmaskable bits bypass the global mask, maskable ones do not
	assign req = {pend_reg & len_reg & {cisu_pkg::N_MASK{~gmask}},
		nmi_reg};
	assign room   = sp_reg <= cisu_pkg::STK_ROOM;
	assign ret_ok = state_reg == cisu_pkg::ST_IDLE &&
		return_from_exception_i && sp_reg >= cisu_pkg::FRAME_LEN;
	assign take   = state_reg == cisu_pkg::ST_IDLE && !ret_ok &&
		pr_valid && room;
	assign stk_rd = stack_mem[sp_reg - 6'h01];

	// fixed priority pick among the gated requests
	cisu_prio_enc u_prio (
		.req_i   (req),
		.valid_o (pr_valid),
		.idx_o   (pr_idx)
	);

	// frame word for the current push slot
	always_comb begin
		case (cnt_reg)
			3'h0:    push_word = {8'h00, condition_flags_reg};
			3'h1:    push_word = double_accumulator_i;
			3'h2:    push_word = index_x_i;
			3'h3:    push_word = index_y_i;
			default: push_word = program_counter_i;
		endcase
	end

	// ----------------------------------------------------------------
	// apb decode
	// ----------------------------------------------------------------
	assign wr_en    = apb_psel_i & apb_penable_i & apb_pwrite_i & addr_hit;
	assign rd_setup = apb_psel_i & ~apb_penable_i & ~apb_pwrite_i;
	assign addr_hit = apb_paddr_i == cisu_pkg::A_COND ||
		apb_paddr_i == cisu_pkg::A_LEN ||
		apb_paddr_i == cisu_pkg::A_PEND ||
		apb_paddr_i == cisu_pkg::A_STAT;

	// read data captured in the setup cycle, zero when unmapped
	always_comb begin
		rdata_next = rdata_reg;
		if (rd_setup) begin
			case (apb_paddr_i)
				cisu_pkg::A_COND: rdata_next = {24'h000000,
					condition_flags_reg};
				cisu_pkg::A_LEN:  rdata_next = {17'h00000, len_reg};
				cisu_pkg::A_PEND: rdata_next = {17'h00000, pend_reg};
				cisu_pkg::A_STAT: begin
					rdata_next = 32'h00000000;
					rdata_next[cisu_pkg::ST_NMI_LSB +: cisu_pkg::N_NMI] =
						nmi_reg;
					rdata_next[cisu_pkg::ST_FSM_LSB +: 2] = state_reg;
					rdata_next[cisu_pkg::ST_SP_LSB +: cisu_pkg::SP_W] =
						sp_reg;
				end
				default: rdata_next = 32'h00000000;
			endcase
		end
	end

	// ----------------------------------------------------------------
	// flags and enables
	// ----------------------------------------------------------------
	always_comb begin
		len_next = len_reg;
		pend_next = pend_reg;
		nmi_clr = '0;
		flags_next = condition_flags_reg;
		if (wr_en && apb_paddr_i == cisu_pkg::A_LEN) begin
			len_next = apb_pwdata_i[cisu_pkg::N_MASK-1:0];
		end
		// software clear first, so a same-cycle event still sets
		if (wr_en && apb_paddr_i == cisu_pkg::A_PEND) begin
			pend_next = pend_reg & ~apb_pwdata_i[cisu_pkg::N_MASK-1:0];
		end
		pend_next = pend_next | evt_en;
		if (take && pr_idx < cisu_pkg::SRC_MASK0) begin
			nmi_clr[pr_idx[2:0]] = 1'b1;
		end
		nmi_next = (nmi_reg & ~nmi_clr) | nmi_set;
		if (wr_en && apb_paddr_i == cisu_pkg::A_COND) begin
			flags_next = apb_pwdata_i[7:0];
		end
		// hardware updates win over a software write
		if (state_reg == cisu_pkg::ST_VEC) begin
			flags_next[cisu_pkg::GMASK_BIT] = 1'b1;
		end else if (state_reg == cisu_pkg::ST_POP &&
			cnt_reg == cisu_pkg::FRAME_LAST) begin
			flags_next = stk_rd[7:0];
		end
	end

	// ----------------------------------------------------------------
	// service sequencer
	// ----------------------------------------------------------------
	always_comb begin
		state_next  = state_reg;
		cnt_next    = cnt_reg;
		sp_next     = sp_reg;
		vidx_next   = vidx_reg;
		vvalid_next = 1'b0;
		rvalid_next = 1'b0;
		dacc_next     = dacc_reg;
		index_x_next  = index_x_reg;
		index_y_next  = index_y_reg;
		prog_cnt_next = prog_cnt_reg;
		case (state_reg)
			cisu_pkg::ST_IDLE: begin
				cnt_next = 3'h0;
				if (ret_ok) begin
					state_next = cisu_pkg::ST_POP;
				end else if (take) begin
					vidx_next = pr_idx;
					// reset has no frame to save
					state_next = (pr_idx == cisu_pkg::SRC_RESET) ?
						cisu_pkg::ST_VEC : cisu_pkg::ST_PUSH;
				end
			end
			cisu_pkg::ST_PUSH: begin
				sp_next  = sp_reg + 6'h01;
				cnt_next = cnt_reg + 3'h1;
				if (cnt_reg == cisu_pkg::FRAME_LAST) begin
					state_next = cisu_pkg::ST_VEC;
				end
			end
			cisu_pkg::ST_VEC: begin
				vvalid_next = 1'b1;
				state_next  = cisu_pkg::ST_IDLE;
			end
			cisu_pkg::ST_POP: begin
				sp_next  = sp_reg - 6'h01;
				cnt_next = cnt_reg + 3'h1;
				// counter, y, x, accumulator, flags: mirror of push order
				case (cnt_reg)
					3'h0:    prog_cnt_next = stk_rd;
					3'h1:    index_y_next  = stk_rd;
					3'h2:    index_x_next  = stk_rd;
					3'h3:    dacc_next     = stk_rd;
					default: rvalid_next = 1'b1;
				endcase
				if (cnt_reg == cisu_pkg::FRAME_LAST) begin
					state_next = cisu_pkg::ST_IDLE;
				end
			end
			default: state_next = cisu_pkg::ST_IDLE;
		endcase
	end

	// registers
	always_ff @(posedge mclk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			state_reg           <= cisu_pkg::ST_IDLE;
			cnt_reg             <= 3'h0;
			sp_reg              <= '0;
			condition_flags_reg <= cisu_pkg::FLAGS_RST;
			len_reg             <= '0;
			pend_reg            <= '0;
			nmi_reg             <= cisu_pkg::NMI_RST;
			xnmi_prev_reg       <= 1'b1;
			vidx_reg            <= '0;
			vvalid_reg          <= 1'b0;
			rvalid_reg          <= 1'b0;
			dacc_reg            <= 16'h0000;
			index_x_reg         <= 16'h0000;
			index_y_reg         <= 16'h0000;
			prog_cnt_reg        <= 16'h0000;
			rdata_reg           <= 32'h00000000;
		end else begin
			state_reg           <= state_next;
			cnt_reg             <= cnt_next;
			sp_reg              <= sp_next;
			condition_flags_reg <= flags_next;
			len_reg             <= len_next;
			pend_reg            <= pend_next;
			nmi_reg             <= nmi_next;
			xnmi_prev_reg       <= external_nmi_request_n_i;
			vidx_reg            <= vidx_next;
			vvalid_reg          <= vvalid_next;
			rvalid_reg          <= rvalid_next;
			dacc_reg            <= dacc_next;
			index_x_reg         <= index_x_next;
			index_y_reg         <= index_y_next;
			prog_cnt_reg        <= prog_cnt_next;
			rdata_reg           <= rdata_next;
		end
	end

	// return stack storage, written only while pushing
	always_ff @(posedge mclk_i) begin
		if (state_reg == cisu_pkg::ST_PUSH) begin
			stack_mem[sp_reg] <= push_word;
		end
	end

	// ----------------------------------------------------------------
	// outputs
	// ----------------------------------------------------------------
	assign apb_prdata_o         = rdata_reg;
	assign apb_pready_o         = 1'b1;
	assign apb_pslverr_o        = apb_psel_i & apb_penable_i & ~addr_hit;
	assign halt_o               = state_reg != cisu_pkg::ST_IDLE;
	assign vector_valid_o       = vvalid_reg;
	assign vector_idx_o         = vidx_reg;
	assign vector_addr_o        = cisu_pkg::VEC_TOP -
		16'({vidx_reg, 1'b0});
	assign restore_valid_o      = rvalid_reg;
	assign condition_flags_o    = condition_flags_reg;
	assign double_accumulator_o = dacc_reg;
	assign index_x_o            = index_x_reg;
	assign index_y_o            = index_y_reg;
	assign program_counter_o    = prog_cnt_reg;
	assign irq_o                = |(pend_reg & len_reg);

	// ----------------------------------------------------------------
	// assertions
	// ----------------------------------------------------------------
	default clocking cb @(posedge mclk_i); endclocking
	default disable iff (!rst_n_i);

	pend_set_a: assert property (
		(evt_en != '0) |=> ((pend_reg & $past(evt_en)) == $past(evt_en)))
		else $error("enabled event did not set pending");
	no_recog_a: assert property (
		##1 ((pend_reg & ~$past(pend_reg) & ~$past(evt_en)) == '0))
		else $error("pending set without enabled event");
	gmask_gate_a: assert property (
		take && pr_idx >= cisu_pkg::SRC_MASK0 |-> !gmask)
		else $error("maskable served while globally masked");
	push_seq_a: assert property (
		take && pr_idx != cisu_pkg::SRC_RESET |=>
		(state_reg == cisu_pkg::ST_PUSH)[*5] ##1
		state_reg == cisu_pkg::ST_VEC ##1 sp_reg == $past(sp_reg, 7) + 6'h05)
		else $error("push frame not five words");
	gmask_set_a: assert property (
		state_reg == cisu_pkg::ST_VEC |=> gmask && vector_valid_o)
		else $error("global mask not set at vector");
	hold_masked_a: assert property (
		state_reg == cisu_pkg::ST_IDLE && gmask && nmi_reg == '0 &&
		!return_from_exception_i |=> state_reg == cisu_pkg::ST_IDLE)
		else $error("maskable left idle while masked");
	nmi_take_a: assert property (
		state_reg == cisu_pkg::ST_IDLE && nmi_reg != '0 && room &&
		!return_from_exception_i |=> state_reg != cisu_pkg::ST_IDLE)
		else $error("nonmaskable request not served");
	vec_addr_a: assert property (
		vector_valid_o |-> vector_addr_o ==
		cisu_pkg::VEC_TOP - 16'({vector_idx_o, 1'b0}))
		else $error("vector address mismatch");
	ret_seq_a: assert property (
		ret_ok |=> (state_reg == cisu_pkg::ST_POP)[*5] ##1
		restore_valid_o && state_reg == cisu_pkg::ST_IDLE)
		else $error("return did not restore frame");
	pop_order_a: assert property (
		state_reg == cisu_pkg::ST_POP && cnt_reg == 3'h0 |=>
		program_counter_o == $past(stk_rd))
		else $error("first popped word is not the program counter");

	nest_c: cover property (state_reg == cisu_pkg::ST_VEC &&
		sp_reg > cisu_pkg::FRAME_LEN);
	masked_c: cover property (take && pr_idx >= cisu_pkg::SRC_MASK0);
	ret_c: cover property (restore_valid_o && !gmask);
	w1c_race_c: cover property (wr_en && apb_paddr_i == cisu_pkg::A_PEND
		&& evt_en != '0);
endmodule // cisu_core

// [bench/cisu_cpu_model.sv]
// cisu_cpu_model: cpu register file that feeds the unit's stacking inputs
// assumes halt_i comes from the unit and is high while it stacks
`timescale 1ns/1ps
module cisu_cpu_model (
	input  wire logic        mclk_i,
	input  wire logic        rst_n_i,
	input  wire logic        halt_i,
	output logic      [15:0] dacc_o,
	output logic      [15:0] index_x_o,
	output logic      [15:0] index_y_o,
	output logic      [15:0] prog_cnt_o
);
	logic [15:0] step_reg;
	logic [15:0] step_next;

	// program keeps changing state while running, frozen while halted
	always_comb begin
		step_next = step_reg;
		if (!halt_i) begin
			step_next = {step_reg[14:0],
				step_reg[15] ^ step_reg[13] ^ step_reg[12] ^ step_reg[10]};
		end
	end

	// state register
	always_ff @(posedge mclk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			step_reg <= 16'hACE1;
		end else begin
			step_reg <= step_next;
		end
	end

	// four distinct views so a swapped restore shows up
	assign dacc_o     = step_reg;
	assign index_x_o  = step_reg ^ 16'h5A5A;
	assign index_y_o  = {step_reg[7:0], step_reg[15:8]};
	assign prog_cnt_o = ~step_reg;
endmodule // cisu_cpu_model

// [bench/cisu_core_test.sv]
// cisu_core_test: self-checking bench for the interrupt service unit
// assumes cisu_pkg, cisu_core and cisu_cpu_model are compiled before it
`timescale 1ns/1ps
module cisu_core_test;
	logic        mclk_i;
	logic        rst_n_i;
	logic        psel, penable, pwrite, pready, pslverr;
	logic [7:0]  paddr;
	logic [31:0] pwdata, prdata, rd;
	logic [14:0] evt;
	logic        clk_fail, wdog, ill_op, trap, xnmi_n, ret;
	logic        halt, vvalid, rvalid, irq, err, found, seen_halt;
	logic [4:0]  vidx;
	logic [15:0] vaddr;
	wire logic [3:0][15:0] cpu;
	wire logic [3:0][15:0] rreg;
	logic [3:0][15:0]      snap;
	logic [7:0]  flags, fl;
	int          mismatches, cmp_count, cycles, a, b, j;

	cisu_core u_cisu_core (.mclk_i(mclk_i), .rst_n_i(rst_n_i),
		.apb_psel_i(psel), .apb_penable_i(penable), .apb_pwrite_i(pwrite),
		.apb_paddr_i(paddr), .apb_pwdata_i(pwdata), .apb_prdata_o(prdata),
		.apb_pready_o(pready), .apb_pslverr_o(pslverr),
		.maskable_evt_i(evt), .clk_fail_i(clk_fail),
		.liveness_watchdog_i(wdog), .illegal_op_i(ill_op),
		.soft_trap_instr_i(trap), .external_nmi_request_n_i(xnmi_n),
		.return_from_exception_i(ret), .double_accumulator_i(cpu[0]),
		.index_x_i(cpu[1]), .index_y_i(cpu[2]), .program_counter_i(cpu[3]),
		.halt_o(halt), .vector_valid_o(vvalid), .vector_idx_o(vidx),
		.vector_addr_o(vaddr), .restore_valid_o(rvalid),
		.condition_flags_o(flags), .double_accumulator_o(rreg[0]),
		.index_x_o(rreg[1]), .index_y_o(rreg[2]),
		.program_counter_o(rreg[3]), .irq_o(irq));

	cisu_cpu_model u_cisu_cpu_model (.mclk_i(mclk_i), .rst_n_i(rst_n_i),
		.halt_i(halt), .dacc_o(cpu[0]), .index_x_o(cpu[1]),
		.index_y_o(cpu[2]), .prog_cnt_o(cpu[3]));

	// ----------------------------------------------------------------
	// clock, timeout and report
	// ----------------------------------------------------------------
	// 10 MHz clock
	initial begin
		mclk_i = 1'h0;
		forever #50 mclk_i = ~mclk_i;
	end

	// cut a hang short
	always @(posedge mclk_i) begin
		cycles++;
		if (cycles == 8000) begin
			mismatches++;
			summarize();
		end
	end

	task automatic summarize();
		if (mismatches == 0 && cmp_count > 0) $display("DONE - PASS");
		else $display("DONE - FAIL");
		$finish;
	endtask

	task automatic chk_val(input string nm, input logic [31:0] e, g);
		cmp_count++;
		if (g !== e) begin
			mismatches++;
			$display("CHECK FAILED %s expected %h seen %h", nm, e, g);
		end
	endtask

	task automatic chk_bit(input string nm, input logic e, g);
		cmp_count++;
		if (g !== e) begin
			mismatches++;
			$display("CHECK FAILED %s expected %b seen %b", nm, e, g);
		end
	endtask

	// ----------------------------------------------------------------
	// drivers
	// ----------------------------------------------------------------
	// one apb transfer: setup, then access until pready
	task automatic apb(input logic wr, input logic [7:0] ad,
			input logic [31:0] wd);
		@(posedge mclk_i);
		psel <= 1'h1;
		penable <= 1'h0;
		pwrite <= wr;
		paddr <= ad;
		pwdata <= wd;
		@(posedge mclk_i);
		penable <= 1'h1;
		do @(posedge mclk_i); while (pready !== 1'h1);
		rd = prdata;
		err = pslverr;
		psel <= 1'h0;
		penable <= 1'h0;
	endtask

	// one-cycle peripheral events, or a nonmaskable source by index
	task automatic pulse(input logic [14:0] m, input int s);
		@(posedge mclk_i);
		evt <= m;
		clk_fail <= (s == 1);
		wdog <= (s == 2);
		ill_op <= (s == 3);
		trap <= (s == 4);
		xnmi_n <= (s != 5);
		@(posedge mclk_i);
		evt <= '0;
		{clk_fail, wdog, ill_op, trap} <= 4'h0;
		xnmi_n <= 1'h1;
	endtask

	// watch for a vector, noting halt and the cpu frame held at stacking
	task automatic wait_vec(input int lim);
		found = 1'h0;
		seen_halt = 1'h0;
		repeat (lim) begin
			@(negedge mclk_i);
			if (halt === 1'h1) seen_halt = 1'h1;
			if (vvalid === 1'h1) begin
				found = 1'h1;
				snap = cpu;
				break;
			end
		end
	endtask

	task automatic take_chk(input int idx);
		wait_vec(16);
		chk_bit("vector", 1'h1, found);
		chk_val("vec_idx", 32'(idx), {27'h0, vidx});
		chk_val("vec_addr", 32'(16'hFFFE - 16'(2 * idx)), {16'h0, vaddr});
		chk_bit("gmask_set", 1'h1, flags[4]);
		chk_bit("halted", 1'h1, seen_halt);
	endtask

	// handler end: clear own flag, return, compare the restored frame
	task automatic give_back(input logic [7:0] sav, input int clr);
		if (clr >= 0) apb(1'h1, cisu_pkg::A_PEND, 32'h1 << clr);
		@(posedge mclk_i);
		ret <= 1'h1;
		@(posedge mclk_i);
		ret <= 1'h0;
		found = 1'h0;
		repeat (12) begin
			@(negedge mclk_i);
			if (rvalid === 1'h1) begin
				found = 1'h1;
				break;
			end
		end
		chk_bit("restore", 1'h1, found);
		chk_val("flags_back", {24'h0, sav}, {24'h0, flags});
		for (int i = 0; i < 4; i++) begin
			chk_val("reg_back", {16'h0, snap[i]}, {16'h0, rreg[i]});
		end
	endtask

	// ----------------------------------------------------------------
	// main sequence
	// ----------------------------------------------------------------
	initial begin
		{rst_n_i, psel, penable, pwrite, ret} = 5'h0;
		{clk_fail, wdog, ill_op, trap} = 4'h0;
		xnmi_n = 1'h1;
		paddr = 8'h00;
		pwdata = 32'h0;
		evt = '0;
		{mismatches, cmp_count, cycles} = '0;
		void'($urandom(28));
		repeat (10) @(posedge mclk_i);
		chk_val("flags_rst", 32'h10, {24'h0, flags});
		rst_n_i <= 1'h1;
		wait_vec(6);
		chk_bit("reset_vec", 1'h1, found);
		chk_val("reset_addr", 32'hFFFE, {16'h0, vaddr});
		fl = 8'($urandom) & 8'hEF;
		apb(1'h1, cisu_pkg::A_COND, {24'h0, fl});
		apb(1'h0, 8'h10, 32'h0);
		chk_bit("slverr", 1'h1, err);
		chk_val("unmapped", 32'h0, rd);
		apb(1'h1, cisu_pkg::A_STAT, 32'hFFFFFFFF);
		apb(1'h0, cisu_pkg::A_STAT, 32'h0);
		chk_val("status", 32'h0, rd);
		// every maskable source: disabled, then served with another held
		for (int k = 0; k < 15; k++) begin
			j = (k + 1 + $urandom_range(13)) % 15;
			apb(1'h1, cisu_pkg::A_LEN, 32'h0);
			pulse(15'h1 << k, 0);
			wait_vec(12);
			chk_bit("no_vector", 1'h0, found);
			apb(1'h0, cisu_pkg::A_PEND, 32'h0);
			chk_val("pend_off", 32'h0, rd);
			apb(1'h1, cisu_pkg::A_LEN, (32'h1 << k) | (32'h1 << j));
			pulse(15'h1 << k, 0);
			take_chk(6 + k);
			chk_bit("irq", 1'h1, irq);
			pulse(15'h1 << j, 0);
			wait_vec(12);
			chk_bit("held", 1'h0, found);
			apb(1'h0, cisu_pkg::A_PEND, 32'h0);
			chk_val("pend", (32'h1 << k) | (32'h1 << j), rd);
			give_back(fl, k);
			take_chk(6 + j);
			give_back(fl, j);
			chk_bit("irq_clr", 1'h0, irq);
		end
		// two at once while masked, lower index first on unmask
		a = $urandom_range(13);
		b = a + 1 + $urandom_range(13 - a);
		apb(1'h1, cisu_pkg::A_COND, {24'h0, fl | 8'h10});
		apb(1'h1, cisu_pkg::A_LEN, 32'h7FFF);
		pulse((15'h1 << a) | (15'h1 << b), 0);
		apb(1'h1, cisu_pkg::A_COND, {24'h0, fl});
		take_chk(6 + a);
		give_back(fl, a);
		take_chk(6 + b);
		give_back(fl, b);
		// nonmaskable sources with the global mask set
		apb(1'h1, cisu_pkg::A_COND, {24'h0, fl | 8'h10});
		for (int s = 1; s < 6; s++) begin
			pulse(15'h0, s);
			take_chk(s);
			give_back(fl | 8'h10, -1);
		end
		summarize();
	end
endmodule // cisu_core_test
